// ===== dv/ssp_link_monitor.sv
// Purpose: Checker beside the link between host and device.
// Assumes: Serial clock is a registered copy of i_clock timing.
// Notes: Bit count kept in the sck domain, rises seen on i_clock.
module ssp_link_monitor (
  input wire logic i_clock, // System clock
  input wire logic i_rst, // Sync reset, active high
  input wire logic sck, // Serial clock
  input wire logic chip_select_n, // Active low select
  input wire logic serial_in, // Host to device data
  input wire logic readback_out // Device to host data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Helper counts
  // ------------------------------------------------------------
  logic [4:0] bit_cnt;
  logic [4:0] rise_cnt;
  logic sck_q;
  always_ff @(posedge sck or posedge chip_select_n)
  begin
    if (chip_select_n)
      bit_cnt <= 5'h00;
    else if (bit_cnt == 5'h17)
      bit_cnt <= 5'h00;
    else
      bit_cnt <= bit_cnt + 5'h01;
  end
  // Counted on i_clock so frame length is judged at select release
  always_ff @(posedge i_clock)
  begin
    sck_q <= sck;
    if (i_rst || chip_select_n)
      rise_cnt <= 5'h00;
    else if (sck && !sck_q)
      rise_cnt <= rise_cnt + 5'h01;
  end
  sequence s_sck_low2;
    !sck [*2];
  endsequence
  sequence s_sck_high2;
    sck [*2];
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_RB_ADDR_LOW: assert property (@(posedge sck) disable iff (i_rst)
    !chip_select_n && bit_cnt < 5'h08 |-> !readback_out)
    else $error("readback not low in address bits");
  AST_RB_AFTER_FALL: assert property (@(posedge i_clock)
    disable iff (i_rst) !chip_select_n && !$past(chip_select_n)
    && $changed(readback_out) |-> $fell(sck))
    else $error("readback changed away from a falling clock");
  AST_RB_IDLE_LOW: assert property (@(posedge i_clock)
    disable iff (i_rst) chip_select_n |-> !readback_out)
    else $error("readback not low while deselected");
  AST_FRAME_24: assert property (@(posedge i_clock)
    disable iff (i_rst) $rose(chip_select_n) |-> rise_cnt == 5'h18)
    else $error("frame did not hold 24 clock rises");
  AST_SCK_IDLE: assert property (@(posedge i_clock)
    disable iff (i_rst) chip_select_n |-> !sck)
    else $error("serial clock high while deselected");
  AST_DATA_HOLD: assert property (@(posedge i_clock)
    disable iff (i_rst) sck && $past(sck) |-> $stable(serial_in))
    else $error("serial input moved while clock high");
  AST_CS_SETUP: assert property (@(posedge i_clock)
    disable iff (i_rst) $fell(chip_select_n) |-> s_sck_low2 ##[1:6] sck)
    else $error("select to first clock rise out of range");
  AST_CS_HOLD: assert property (@(posedge i_clock)
    disable iff (i_rst) $rose(chip_select_n) |-> !$past(sck, 1)
    && !$past(sck, 2))
    else $error("select released too soon after clock");
  AST_SCK_HIGH: assert property (@(posedge i_clock)
    disable iff (i_rst) $rose(sck) |-> s_sck_high2)
    else $error("serial clock high pulse too short");
endmodule

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for host and device facing each other.
// Assumes: Host makes the serial clock; bench makes the reference.
// Notes: Read frames carry junk data bits on purpose.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_rst, ref_clk, sync_in, pulse_req;
  logic cmd_valid, cmd_read, cmd_ready, rd_valid;
  logic [6:0] cmd_addr, wr_addr, seen_a;
  logic [15:0] cmd_data, rd_data, wr_data, seen_d;
  logic wr_valid, link_busy, sync_level, pulse_level;
  logic wr_seen, rd_seen, busy_seen;
  int bad_count = 0;
  int samples_checked = 0;
  ssp_link_if ssp_link_if_inst ();
  ssp_host ssp_host_inst (.i_clock(i_clock), .i_rst(i_rst),
    .link(ssp_link_if_inst), .i_cmd_valid(cmd_valid),
    .i_cmd_read(cmd_read), .i_cmd_addr(cmd_addr), .i_cmd_data(cmd_data),
    .o_cmd_ready(cmd_ready), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
  ssp_device ssp_device_inst (.i_clock(i_clock), .i_rst(i_rst),
    .link(ssp_link_if_inst), .i_reference_clock_in(ref_clk),
    .i_sync_in(sync_in), .i_ref_pulse_request(pulse_req),
    .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
    .o_link_busy(link_busy), .o_sync_level(sync_level),
    .o_ref_pulse_request(pulse_level));
  ssp_link_monitor ssp_link_monitor_inst (.i_clock(i_clock),
    .i_rst(i_rst), .sck(ssp_link_if_inst.sck),
    .chip_select_n(ssp_link_if_inst.chip_select_n),
    .serial_in(ssp_link_if_inst.serial_in),
    .readback_out(ssp_link_if_inst.readback_out));
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // Odd offset keeps the reference unrelated to i_clock
  initial
  begin
    ref_clk = 1'b0;
    #3;
    forever #15 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic op(input logic rd, input logic [6:0] a,
    input logic [15:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 500)
    begin
      @(negedge i_clock);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_addr = a;
    cmd_data = d;
    @(negedge i_clock);
    cmd_valid = 1'b0;
    wr_seen = 1'b0;
    rd_seen = 1'b0;
    busy_seen = 1'b0;
    @(negedge i_clock);
    while (cmd_ready !== 1'b1 && n < 500)
    begin
      if (wr_valid === 1'b1)
      begin
        wr_seen = 1'b1;
        seen_a = wr_addr;
        seen_d = wr_data;
      end
      if (rd_valid === 1'b1)
        rd_seen = 1'b1;
      if (link_busy === 1'b1)
        busy_seen = 1'b1;
      @(negedge i_clock);
      n++;
    end
    if (n >= 500)
    begin
      bad_count++;
      $display("mismatch at %0t: command never completed", $time);
    end
    check({15'h0000, busy_seen}, 16'h0001);
    check({15'h0000, link_busy}, 16'h0000);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    op(1'b0, a, d);
    check({15'h0000, wr_seen}, 16'h0001);
    check({9'h000, seen_a}, {9'h000, a});
    check(seen_d, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] junk,
    input logic [15:0] exp);
    op(1'b1, a, junk);
    check({15'h0000, rd_seen}, 16'h0001);
    check({15'h0000, wr_seen}, 16'h0000);
    check(rd_data, exp);
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    i_rst = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_addr = 7'h00;
    cmd_data = 16'h0000;
    sync_in = 1'b0;
    pulse_req = 1'b0;
    // Raised after time zero so the asynchronous clears see an edge
    @(negedge i_clock);
    i_rst = 1'b1;
    repeat (20) @(negedge i_clock);
    check({15'h0000, wr_valid}, 16'h0000);
    check({15'h0000, ssp_link_if_inst.readback_out}, 16'h0000);
    i_rst = 1'b0;
    @(negedge i_clock);
    check({15'h0000, link_busy}, 16'h0000);
    @(negedge i_clock);
    check({15'h0000, link_busy}, 16'h0000);
    $display("test reset done");
    wr(7'h00, 16'ha5c3);
    wr(7'h7f, 16'hffff);
    wr(7'h2a, 16'h8001);
    wr(7'h01, 16'h0001);
    rd(7'h00, 16'h0000, 16'ha5c3);
    rd(7'h7f, 16'h0000, 16'hffff);
    rd(7'h2a, 16'hffff, 16'h8001);
    rd(7'h2a, 16'h0000, 16'h8001);
    rd(7'h01, 16'hfffe, 16'h0001);
    rd(7'h11, 16'h5a5a, 16'h0000);
    wr(7'h2a, 16'h7ffe);
    rd(7'h2a, 16'h0000, 16'h7ffe);
    $display("test write_read done");
    for (int k = 0; k < 4; k++)
    begin
      @(negedge ref_clk);
      sync_in = k[0];
      pulse_req = k[1];
      repeat (12) @(negedge i_clock);
      check({15'h0000, sync_level}, {15'h0000, k[0]});
      check({15'h0000, pulse_level}, {15'h0000, k[1]});
    end
    $display("test ref_sample done");
    complete_run();
  end
  initial
  begin
    repeat (20000) @(posedge i_clock);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule

// ===== hdl/ssp_device.sv
// Purpose: Serial programming port of a wideband synthesizer.
// Assumes: Host is the link master; serial clock idles low.
// Notes: Frame logic runs on the serial clock; registers on i_clock.
//
// Overview of operation
// (R1) Host sends read/write flag 0 for writes
// (R2) Serial input shifted in on rising clock
// (R3) Clock pulses ignored while chip select high
// (R4) Host keeps unaddressed devices deselected
// (R5) Host sends read/write flag 1 for readback
// (R6) Readback output low during address bits
// (R7) Readback changes after falling edge, sampled rising
// (R8) Serial input ignored during readback data
// (R9) Sync and pulse request sampled on reference
// (R10) 24-bit frame: flag, 7-bit address, 16 data
module ssp_device (
  input wire logic i_clock, // System clock
  input wire logic i_rst, // Reset, active high; synchronous on i_clock, asynchronous for hold and ref_smp
  ssp_link_if.dev link, // Serial link from the host
  input wire logic i_reference_clock_in, // Reference oscillator
  input wire logic i_sync_in, // Sync, reference-synchronous
  input wire logic i_ref_pulse_request, // Pulse request, ref-synchronous
  output logic o_wr_valid, // Register written, one-cycle pulse
  output logic [6:0] o_wr_addr, // Address of the written register
  output logic [15:0] o_wr_data, // Data of the written register
  output logic o_link_busy, // Chip select seen asserted
  output logic o_sync_level, // Sampled sync level
  output logic o_ref_pulse_request // Sampled pulse request level
);
  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [ssp_pkg::CNT_BITS-1:0] count;
    logic [ssp_pkg::FRAME_BITS-2:0] shift;
    logic rw;
    logic [ssp_pkg::ADDR_BITS-1:0] addr;
  } ssp_frame_type;

  typedef struct packed {
    logic toggle;
    logic [ssp_pkg::ADDR_BITS-1:0] addr;
    logic [ssp_pkg::DATA_BITS-1:0] data;
  } ssp_hold_type;

  typedef struct packed {
    logic [ssp_pkg::REG_DEPTH-1:0][ssp_pkg::DATA_BITS-1:0] regs;
    logic seen;
    logic wr_valid;
    logic [ssp_pkg::ADDR_BITS-1:0] wr_addr;
    logic [ssp_pkg::DATA_BITS-1:0] wr_data;
    logic busy;
    logic sync_level;
    logic ref_req;
  } ssp_sys_type;

  ssp_frame_type frame;
  ssp_frame_type next_frame;
  ssp_hold_type hold;
  ssp_hold_type next_hold;
  ssp_sys_type sys;
  ssp_sys_type next_sys;
  logic out_bit;
  logic next_out_bit;
  logic [ssp_pkg::DATA_BITS-1:0] rdata;
  logic [1:0] ref_smp;
  logic toggle_s;
  logic [2:0] pins_s;

  // ------------------------------------------------------------------
  // Frame receiver, serial clock domain
  // ------------------------------------------------------------------
  always_comb
  begin
    next_frame = frame;
    next_frame.shift = {frame.shift[ssp_pkg::FRAME_BITS-3:0],
                        link.serial_in}; // [R2]
    if (frame.count == ssp_pkg::CNT_RW)
      next_frame.rw = link.serial_in; // [R10]
    if (frame.count == ssp_pkg::CNT_ADDR_LAST)
      next_frame.addr = {frame.shift[ssp_pkg::ADDR_BITS-2:0],
                         link.serial_in}; // [R10]
    if (frame.count == ssp_pkg::CNT_LAST)
      next_frame.count = '0;
    else
      next_frame.count = frame.count + 1'b1;
  end

  // Deselect ends the frame, since the clock may stop right after it
  always_ff @(posedge link.sck or posedge link.chip_select_n)
  begin
    if (link.chip_select_n)
      frame <= '0; // [R3]
    else
      frame <= next_frame; // [R2]
  end

  // ------------------------------------------------------------------
  // Completed write, held until the next write completes
  // ------------------------------------------------------------------
  always_comb
  begin
    next_hold = hold;
    if (!link.chip_select_n && frame.count == ssp_pkg::CNT_LAST &&
        frame.rw == ssp_pkg::RW_WRITE) // [R1] [R3] [R8]
    begin
      next_hold.toggle = ~hold.toggle;
      next_hold.addr = frame.addr;
      next_hold.data = {frame.shift[ssp_pkg::DATA_BITS-2:0],
                        link.serial_in}; // [R10]
    end
  end

  always_ff @(posedge link.sck or posedge i_rst)
  begin
    if (i_rst)
      hold <= '0;
    else
      hold <= next_hold;
  end

  // ------------------------------------------------------------------
  // Readback driver, falling serial clock edge
  // ------------------------------------------------------------------
  // Registers are quasi-static: a write lands long before the next
  // frame reaches its data bits, so the word is stable when read.
  assign rdata = sys.regs[frame.addr];

  always_comb
  begin
    next_out_bit = 1'b0; // [R6]
    if (frame.rw == ssp_pkg::RW_READ &&
        frame.count >= ssp_pkg::CNT_DATA_FIRST) // [R5]
      next_out_bit = rdata[4'(ssp_pkg::CNT_LAST - frame.count)]; // [R7]
  end

  always_ff @(negedge link.sck or posedge link.chip_select_n)
  begin
    if (link.chip_select_n)
      out_bit <= 1'b0; // [R6]
    else
      out_bit <= next_out_bit; // [R7]
  end

  assign link.readback_out = out_bit;

  // ------------------------------------------------------------------
  // Reference-synchronous inputs
  // ------------------------------------------------------------------
  always_ff @(posedge i_reference_clock_in or posedge i_rst)
  begin
    if (i_rst)
      ref_smp <= '0;
    else
      ref_smp <= {i_ref_pulse_request, i_sync_in}; // [R9]
  end

  // ------------------------------------------------------------------
  // Crossings into the system clock domain
  // ------------------------------------------------------------------
  ssp_sync2 #(.WIDTH(1)) u_toggle_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(hold.toggle),
    .o_sync(toggle_s)
  );

  // Select crosses as active high, so the cleared synchroniser already
  // matches an idle link and no false busy pulse follows reset
  ssp_sync2 #(.WIDTH(3)) u_pin_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async({~link.chip_select_n, ref_smp}),
    .o_sync(pins_s)
  );

  // ------------------------------------------------------------------
  // Register file, system clock domain
  // ------------------------------------------------------------------
  always_comb
  begin
    next_sys = sys;
    next_sys.wr_valid = 1'b0;
    // Address and data are stable while the toggle differs
    if (toggle_s != sys.seen)
    begin
      next_sys.seen = toggle_s;
      next_sys.wr_valid = 1'b1;
      next_sys.wr_addr = hold.addr;
      next_sys.wr_data = hold.data;
      next_sys.regs[hold.addr] = hold.data;
    end
    next_sys.busy = pins_s[2]; // [R3]
    next_sys.sync_level = pins_s[0]; // [R9]
    next_sys.ref_req = pins_s[1]; // [R9]
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      sys <= '0;
      sys.regs <= {ssp_pkg::REG_DEPTH{ssp_pkg::REG_RESET}};
    end
    else
      sys <= next_sys;
  end

  assign o_wr_valid = sys.wr_valid;
  assign o_wr_addr = sys.wr_addr;
  assign o_wr_data = sys.wr_data;
  assign o_link_busy = sys.busy;
  assign o_sync_level = sys.sync_level;
  assign o_ref_pulse_request = sys.ref_req;
endmodule

// ===== hdl/ssp_host.sv
// Purpose: Link master that writes and reads back synthesizer words.
// Assumes: One command at a time; serial clock idles low (mode 0).
// Notes: Serial clock is a divided copy of i_clock, not a second domain.
module ssp_host (
  input wire logic i_clock, // System clock
  input wire logic i_rst, // Synchronous reset, active high
  ssp_link_if.host link, // Serial link to the device
  input wire logic i_cmd_valid, // Command request
  input wire logic i_cmd_read, // 1 readback, 0 write
  input wire logic [6:0] i_cmd_addr, // Register address
  input wire logic [15:0] i_cmd_data, // Write data
  output logic o_cmd_ready, // Ready for a command
  output logic o_rd_valid, // Readback word pulse
  output logic [15:0] o_rd_data // Readback word
);
  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH,
    ST_HOLD,
    ST_GAP
  } ssp_host_st_type;

  typedef struct packed {
    ssp_host_st_type state;
    logic [ssp_pkg::DIV_BITS-1:0] timer;
    logic [ssp_pkg::CNT_BITS-1:0] bit_idx;
    logic [ssp_pkg::FRAME_BITS-1:0] tx;
    logic [ssp_pkg::DATA_BITS-1:0] rx;
    logic read;
    logic sck;
    logic cs_n;
    logic sdo;
    logic ready;
    logic rd_valid;
  } ssp_host_type;

  ssp_host_type st;
  ssp_host_type next_st;
  logic rb_sync;
  logic rw_bit;

  // Readback comes from the device's serial clock domain
  ssp_sync2 #(.WIDTH(1)) u_rb_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(link.readback_out),
    .o_sync(rb_sync)
  );

  assign rw_bit = i_cmd_read ? ssp_pkg::RW_READ : ssp_pkg::RW_WRITE;

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    if (st.timer != '0)
      next_st.timer = st.timer - 1'b1;
    unique case (st.state)
      ST_IDLE:
      begin
        next_st.ready = 1'b1;
        if (i_cmd_valid && st.ready)
        begin
          next_st.tx = {rw_bit, i_cmd_addr, i_cmd_data}; // [R1] [R5] [R10]
          next_st.sdo = rw_bit;
          next_st.read = i_cmd_read;
          next_st.cs_n = 1'b0; // [R3] [R4]
          next_st.bit_idx = '0;
          next_st.timer = ssp_pkg::ECS_CYC;
          next_st.ready = 1'b0;
          next_st.state = ST_LOW;
        end
      end
      ST_LOW:
        if (st.timer == '0)
        begin
          next_st.sck = 1'b1;
          next_st.timer = ssp_pkg::HALF_CYC;
          next_st.state = ST_HIGH;
          if (st.bit_idx >= ssp_pkg::CNT_DATA_FIRST)
            next_st.rx = {st.rx[ssp_pkg::DATA_BITS-2:0], rb_sync}; // [R7]
        end
      ST_HIGH:
        if (st.timer == '0)
        begin
          next_st.sck = 1'b0;
          if (st.bit_idx == ssp_pkg::CNT_LAST)
          begin
            next_st.timer = ssp_pkg::CE_CYC;
            next_st.state = ST_HOLD;
          end
          else
          begin
            next_st.timer = ssp_pkg::HALF_CYC;
            next_st.bit_idx = st.bit_idx + 1'b1;
            next_st.tx = {st.tx[ssp_pkg::FRAME_BITS-2:0], 1'b0};
            next_st.sdo = st.tx[ssp_pkg::FRAME_BITS-2];
            next_st.state = ST_LOW;
          end
        end
      ST_HOLD:
        if (st.timer == '0)
        begin
          next_st.cs_n = 1'b1; // [R3]
          next_st.rd_valid = st.read;
          next_st.timer = ssp_pkg::EWH_CYC;
          next_st.state = ST_GAP;
        end
      ST_GAP:
        if (st.timer == '0)
          next_st.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      st <= '0;
      st.cs_n <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign link.sck = st.sck;
  assign link.chip_select_n = st.cs_n;
  assign link.serial_in = st.sdo;
  assign o_cmd_ready = st.ready;
  assign o_rd_valid = st.rd_valid;
  assign o_rd_data = st.rx;
endmodule

// ===== hdl/ssp_link_if.sv
// Purpose: Serial programming link between host and synthesizer port.
// Assumes: Push-pull lines only; the host makes the serial clock.
// Notes: No clocking block; each end samples as it needs.
interface ssp_link_if;
  logic sck;
  logic chip_select_n;
  logic serial_in;
  logic readback_out;

  modport host (
    output sck,
    output chip_select_n,
    output serial_in,
    input readback_out
  );

  modport dev (
    input sck,
    input chip_select_n,
    input serial_in,
    output readback_out
  );
endinterface

// ===== hdl/ssp_pkg.sv
// Purpose: Shared constants of the synthesizer serial programming port.
// Assumes: 125 MHz system clock; one 24-bit frame per chip select.
// Notes: Host timing counts are derived from the readback limits.
package ssp_pkg;
  // ------------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int ADDR_BITS = 7;
  localparam int DATA_BITS = 16;
  localparam int CNT_BITS = 5;
  localparam int REG_DEPTH = 128;
  localparam logic [CNT_BITS-1:0] CNT_RW = 5'h00;
  localparam logic [CNT_BITS-1:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [CNT_BITS-1:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [CNT_BITS-1:0] CNT_LAST = 5'h17;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [DATA_BITS-1:0] REG_RESET = 16'h0000;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SYNC_STAGES = 2;
  localparam int T_CWH_NS = 10;
  localparam int T_ECS_NS = 10;
  localparam int T_CE_NS = 10;
  localparam int T_EWH_NS = 10;
  localparam int DIV_BITS = 4;
  // Half period leaves room for the readback synchroniser
  localparam logic [DIV_BITS-1:0] HALF_CYC = DIV_BITS'(
    (T_CWH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  localparam logic [DIV_BITS-1:0] ECS_CYC = DIV_BITS'(
    (T_ECS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DIV_BITS-1:0] CE_CYC = DIV_BITS'(
    (T_CE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DIV_BITS-1:0] EWH_CYC = DIV_BITS'(
    (T_EWH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// ===== hdl/ssp_sync2.sv
// Purpose: Two flip-flop level synchroniser.
// Assumes: Inputs are levels that stay put for several cycles.
// Notes: The first stage feeds only the second stage.
module ssp_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock, // Destination clock
  input wire logic i_rst, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] i_async, // Level from another domain
  output logic [WIDTH-1:0] o_sync // Synchronised level
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule
